//--- pkg/bir_pkg.sv
// constants for the board interrupt router
package bir_pkg;
   // ****************************************
   // register map, byte addresses
   // ****************************************
   localparam int AW = 6;
   localparam logic [5:0] OFS_STATUS = 6'h00;
   localparam logic [5:0] OFS_CLEAR = 6'h04;
   localparam logic [5:0] OFS_ENABLE = 6'h08;
   localparam logic [5:0] OFS_VMASK = 6'h0C;
   localparam logic [5:0] OFS_AUTOV = 6'h10;
   localparam logic [5:0] OFS_RATE = 6'h14;
   localparam logic [5:0] OFS_SERVEC = 6'h18;
   localparam logic [5:0] OFS_VPEND = 6'h1C;
   localparam logic [5:0] OFS_VECTOR = 6'h20;
   // ****************************************
   // local source bits
   // ****************************************
   localparam int NSRC = 11;
   localparam int B_SER0 = 0;
   localparam int B_ALARM = 3;
   localparam int B_PERIOD = 4;
   localparam int B_TMR0 = 5;
   localparam int B_PARITY = 8;
   localparam int B_ACFAIL = 9;
   localparam int B_SYSFAIL = 10;
   localparam int NSER = 3;
   // ****************************************
   // reset values and vectors
   // ****************************************
   localparam logic [7:1] VMASK_RST = 7'h7_F;
   localparam logic [7:1] AUTOV_OK = 7'h1_5;
   localparam logic [7:0] AUTOV_BASE = 8'h1_8;
   localparam logic [7:0] LOCAL_BASE = 8'h4_0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ****************************************
   // periodic rates
   // ****************************************
   localparam int CLK_HZ = 20_000_000;
   localparam int PER_FAST_HZ = 100;
   localparam int PER_BASE_CYC = CLK_HZ / PER_FAST_HZ;
   localparam int NRATE = 6;
   localparam int DIV [1:5] = '{10, 10, 60, 60, 24};
endpackage

//--- verilog/bir_router.sv
// board interrupt router with axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module bir_router #(
   parameter int PER_CYC = bir_pkg::PER_BASE_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [5:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [7:1] vme_irq_n,
   input wire logic abort_n,
   input wire logic [2:0] ser_irq,
   input wire logic rtc_alarm,
   input wire logic [2:0] tmr_irq,
   input wire logic parity_err,
   input wire logic acfail_n,
   input wire logic sysfail_n,
   output logic mirq,
   output logic nmi,
   output logic [7:0] irq_vector,
   output logic vec_from_bus
);
   localparam int NS = bir_pkg::NSRC;
   localparam int NPIN = 18;

   function automatic logic mapped(input logic [5:0] a);
      case (a)
         bir_pkg::OFS_STATUS, bir_pkg::OFS_CLEAR,
         bir_pkg::OFS_ENABLE, bir_pkg::OFS_VMASK,
         bir_pkg::OFS_AUTOV, bir_pkg::OFS_RATE,
         bir_pkg::OFS_SERVEC, bir_pkg::OFS_VPEND,
         bir_pkg::OFS_VECTOR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o,
         input logic [31:0] d, input logic [3:0] s);
      merge = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            merge[8*i +: 8] = d[8*i +: 8];
         end
      end
   endfunction

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [NPIN-1:0] raw;
   logic [NPIN-1:0] s1;
   logic [NPIN-1:0] s2;
   logic [NS-1:0] loc_d;
   logic [NS-1:0] loc_lvl;
   logic [7:1] vme_lvl;
   logic abort_lvl;

   assign raw = {~sysfail_n, ~acfail_n, parity_err, tmr_irq,
      rtc_alarm, ser_irq, ~abort_n, ~vme_irq_n};
   assign vme_lvl = s2[6:0];
   assign abort_lvl = s2[7];
   // periodic slot is filled by the internal tick, not a pin
   assign loc_lvl = {s2[17:12], 1'b0, s2[11:8]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1 <= '0;
         s2 <= '0;
         loc_d <= '0;
      end else begin
         s1 <= raw;
         s2 <= s1;
         loc_d <= loc_lvl;
      end
   end

   // ****************************************
   // periodic tick chain
   // ****************************************
   logic [17:0] base_cnt;
   logic [17:0] next_base_cnt;
   logic [bir_pkg::NRATE-1:0] tick;

   always_comb begin
      next_base_cnt = base_cnt + 18'h0_0001;
      if (base_cnt == 18'(PER_CYC - 1)) begin
         next_base_cnt = '0;
      end
   end
   assign tick[0] = (base_cnt == 18'(PER_CYC - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base_cnt <= '0;
      end else begin
         base_cnt <= next_base_cnt;
      end
   end

   // each stage divides the tick of the stage below it
   for (genvar k = 1; k < bir_pkg::NRATE; k++) begin : g_div
      logic [5:0] cnt;
      logic [5:0] next_cnt;
      logic wrap;
      assign wrap = (cnt == 6'(bir_pkg::DIV[k] - 1));
      assign tick[k] = tick[k-1] & wrap;
      always_comb begin
         next_cnt = cnt;
         if (tick[k-1]) begin
            next_cnt = wrap ? 6'h0_0 : cnt + 6'h0_1;
         end
      end
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            cnt <= '0;
         end else begin
            cnt <= next_cnt;
         end
      end
   end

   // ****************************************
   // register file and bus slave
   // ****************************************
   logic [NS-1:0] status, next_status;
   logic [NS-1:0] enable, next_enable;
   logic [7:1] vmask, next_vmask;
   logic [7:1] autov, next_autov;
   logic [2:0] rate, next_rate;
   logic [23:0] servec, next_servec;
   logic aw_held, next_aw_held;
   logic w_held, next_w_held;
   logic [5:0] wa, next_wa;
   logic [31:0] wd, next_wd;
   logic [3:0] ws, next_ws;
   logic next_awready, next_wready, next_arready;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [NS-1:0] ev;
   logic [31:0] m;
   logic per_ev;

   assign per_ev = (rate < 3'(bir_pkg::NRATE)) && tick[rate];
   assign ev = ((loc_lvl & ~loc_d) & ~(NS'(1) << bir_pkg::B_PERIOD))
      | (NS'(per_ev) << bir_pkg::B_PERIOD);

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_wa = wa;
      next_wd = wd;
      next_ws = ws;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      next_enable = enable;
      next_vmask = vmask;
      next_autov = autov;
      next_rate = rate;
      next_servec = servec;
      m = '0;
      next_status = status;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_wa = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_wd = wdata;
         next_ws = wstrb;
      end
      if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_held && w_held && !bvalid) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = mapped(wa) ? bir_pkg::RESP_OKAY
            : bir_pkg::RESP_SLVERR;
         case (wa)
            bir_pkg::OFS_CLEAR: begin
               m = merge('0, wd, ws);
               next_status = status & ~m[NS-1:0];
            end
            bir_pkg::OFS_ENABLE: begin
               m = merge(32'(enable), wd, ws);
               next_enable = m[NS-1:0];
            end
            bir_pkg::OFS_VMASK: begin
               m = merge(32'({vmask, 1'b0}), wd, ws);
               next_vmask = m[7:1];
            end
            bir_pkg::OFS_AUTOV: begin
               m = merge(32'({autov, 1'b0}), wd, ws);
               next_autov = m[7:1] & bir_pkg::AUTOV_OK;
            end
            bir_pkg::OFS_RATE: begin
               m = merge(32'(rate), wd, ws);
               next_rate = m[2:0];
            end
            bir_pkg::OFS_SERVEC: begin
               m = merge(32'(servec), wd, ws);
               next_servec = m[23:0];
            end
            default: begin
               m = '0;
            end
         endcase
      end
      // new events beat a clear in the same cycle
      next_status = next_status | ev;
      if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = mapped(araddr) ? bir_pkg::RESP_OKAY
            : bir_pkg::RESP_SLVERR;
         case (araddr)
            bir_pkg::OFS_STATUS: next_rdata = 32'(status);
            bir_pkg::OFS_ENABLE: next_rdata = 32'(enable);
            bir_pkg::OFS_VMASK: next_rdata = 32'({vmask, 1'b0});
            bir_pkg::OFS_AUTOV: next_rdata = 32'({autov, 1'b0});
            bir_pkg::OFS_RATE: next_rdata = 32'(rate);
            bir_pkg::OFS_SERVEC: next_rdata = 32'(servec);
            bir_pkg::OFS_VPEND: next_rdata = 32'({vme_lvl, 1'b0});
            bir_pkg::OFS_VECTOR:
               next_rdata = 32'({vec_from_bus, irq_vector});
            default: next_rdata = '0;
         endcase
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wa <= '0;
         wd <= '0;
         ws <= '0;
         awready <= 1'b1;
         wready <= 1'b1;
         arready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= bir_pkg::RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= bir_pkg::RESP_OKAY;
         rdata <= '0;
         status <= '0;
         enable <= '0;
         vmask <= bir_pkg::VMASK_RST;
         autov <= '0;
         rate <= '0;
         servec <= '0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         wa <= next_wa;
         wd <= next_wd;
         ws <= next_ws;
         awready <= next_awready;
         wready <= next_wready;
         arready <= next_arready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         status <= next_status;
         enable <= next_enable;
         vmask <= next_vmask;
         autov <= next_autov;
         rate <= next_rate;
         servec <= next_servec;
      end
   end

   // ****************************************
   // request merge and vector choice
   // ****************************************
   logic [7:1] vme_req;
   logic [NS-1:0] pend;
   logic next_mirq, next_nmi, next_vbus;
   logic [7:0] next_vec;

   // level 7 is never maskable; it goes to nmi only
   assign vme_req = {1'b0, vme_lvl[6:1] & ~vmask[6:1]};
   assign pend = status & enable;

   always_comb begin
      next_vec = '0;
      next_vbus = 1'b0;
      for (int i = NS - 1; i >= 0; i--) begin
         if (pend[i]) begin
            next_vec = bir_pkg::LOCAL_BASE + 8'(i);
            if (i < bir_pkg::NSER) begin
               next_vec = servec[8*i +: 8];
            end
         end
      end
      // higher vme levels win over lower ones and local sources
      for (int l = 1; l < 7; l++) begin
         if (vme_req[l]) begin
            if (autov[l]) begin
               next_vec = bir_pkg::AUTOV_BASE + 8'(l);
               next_vbus = 1'b0;
            end else begin
               next_vec = '0;
               next_vbus = 1'b1;
            end
         end
      end
      next_mirq = (|pend) || (|vme_req);
      next_nmi = vme_lvl[7] || abort_lvl;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mirq <= 1'b0;
         nmi <= 1'b0;
         irq_vector <= '0;
         vec_from_bus <= 1'b0;
      end else begin
         mirq <= next_mirq;
         nmi <= next_nmi;
         irq_vector <= next_vec;
         vec_from_bus <= next_vbus;
      end
   end
endmodule

//--- tb/bir_src_model.sv
// far-side model: vme interrupters, abort switch and local devices
`timescale 1ns/1ns
module bir_src_model (
   input wire logic [7:1] vme_req,
   input wire logic abort_req,
   input wire logic [10:0] loc_req,
   output logic [7:1] vme_irq_n,
   output logic abort_n,
   output logic [2:0] ser_irq,
   output logic rtc_alarm,
   output logic [2:0] tmr_irq,
   output logic parity_err,
   output logic acfail_n,
   output logic sysfail_n
);
   // vme, abort, acfail and sysfail lines are active low and driven by inversion, so a released line reads high; the other local lines are active high
   assign vme_irq_n = ~vme_req;
   assign abort_n = ~abort_req;
   assign ser_irq = loc_req[2:0];
   assign rtc_alarm = loc_req[3];
   assign tmr_irq = loc_req[7:5];
   assign parity_err = loc_req[8];
   assign acfail_n = ~loc_req[9];
   assign sysfail_n = ~loc_req[10];
endmodule

//--- tb/bir_router_sva.sv
// port checker for the board interrupt router
`timescale 1ns/1ns
module bir_router_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [7:1] vme_irq_n,
   input wire logic abort_n,
   input wire logic mirq,
   input wire logic nmi
);
   logic [2:0] age;
   logic [5:0] aw_a;
   logic [6:1] wd;
   logic [6:1] msk;
   logic bv_q;
   wire logic vme_on = |(~vme_irq_n[6:1] & ~msk);
   wire logic nmi_src = ~vme_irq_n[7] | ~abort_n;
   // shadow mask moves one edge after the register, in step with mirq;
   // waiting for the b handshake instead would lag by the master's bready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         age <= 3'h0;
         msk <= 6'h3F;
         bv_q <= 1'b0;
      end else begin
         bv_q <= bvalid;
         if (age != 3'h7) age <= age + 3'h1;
         if (awvalid && awready) aw_a <= awaddr;
         if (wvalid && wready) wd <= wdata[6:1];
         if (bvalid && !bv_q && aw_a == bir_pkg::OFS_VMASK) msk <= wd;
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_take; awvalid && awready && wvalid && wready; endsequence
   sequence rd_take; arvalid && arready; endsequence
   nmi_follow_a: assert property (
      age > 3'h3 |-> nmi == $past(nmi_src, 3))
      else $error("nmi not following level seven and abort");
   vme_unmasked_a: assert property (
      age > 3'h4 && vme_on && $past(vme_on) && $past(vme_on, 2)
      && $past(vme_on, 3) |-> mirq) else $error("unmasked level lost");
   wr_answer_a: assert property (wr_take |=> !bvalid ##1 bvalid)
      else $error("write answer late or early");
   wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response not held");
   wr_refuse_a: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   wr_unmapped_a: assert property (wr_take and awaddr > bir_pkg::OFS_VECTOR
      |-> ##2 bresp == bir_pkg::RESP_SLVERR) else $error("no slave error");
   rd_answer_a: assert property (rd_take |=> rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (rvalid && !rready |=> rvalid)
      else $error("read data dropped");
   rd_refuse_a: assert property (rvalid |-> !arready)
      else $error("read taken while data pending");
endmodule
bind bir_router bir_router_chk u_chk (.*);

//--- tb/board_interrupt_router_test.sv
// self-checking bench for the board interrupt router
`timescale 1ns/1ns
module board_interrupt_router_test;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [5:0] awaddr = 6'h0, araddr = 6'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, abort_req = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, mirq, nmi;
   logic abort_n, rtc_alarm, parity_err, acfail_n, sysfail_n;
   logic vec_from_bus;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] irq_vector;
   logic [7:1] vme_req = 7'h0, vme_irq_n;
   logic [10:0] loc_req = 11'h0;
   logic [2:0] ser_irq, tmr_irq;
   logic [5:0] ra [4] = '{bir_pkg::OFS_ENABLE, bir_pkg::OFS_VMASK,
      bir_pkg::OFS_AUTOV, 6'h30};
   int rates [4] = '{0, 1, 2, 6};
   int waits [4] = '{12, 50, 410, 60};
   int num_errors = 0, compares = 0;
   always #25 aclk = ~aclk;
   bir_router #(.PER_CYC(4)) u_bir_router (.*);
   bir_src_model u_bir_src_model (.*);
   // ****************************************
   // bus tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic axw(input logic [5:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
         // late ready on purpose so the slave must hold its answer
         if (bvalid) bready <= 1'b1;
      end
   endtask
   task automatic axr(input logic [5:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            rd = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
         if (rvalid) rready <= 1'b1;
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (5000) @(posedge aclk);
      num_errors++;
      conclude();
   end
   initial begin
      tick(16);
      aresetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         axr(ra[i]);
         chk("reset value", rd, (i == 1) ? 32'hFE : 32'h0);
         chk("read resp", 32'(resp), (i == 3) ? 32'h2 : 32'h0);
      end
      axw(6'h30, 32'hFFFF_FFFF);
      chk("write resp", 32'(resp), 32'(bir_pkg::RESP_SLVERR));
      axw(bir_pkg::OFS_SERVEC, 32'h00C2_C1C0);
      // only lane 1 enabled: lanes 0 and 2 must keep their vectors
      wstrb <= 4'h2;
      axw(bir_pkg::OFS_SERVEC, 32'hFFFF_C1FF);
      wstrb <= 4'hF;
      axr(bir_pkg::OFS_SERVEC);
      chk("byte lanes", rd, 32'h00C2_C1C0);
      axw(bir_pkg::OFS_RATE, 32'h6);
      axw(bir_pkg::OFS_CLEAR, 32'h7FF);
      $display("test registers done");
      for (int i = 0; i < bir_pkg::NSRC; i++) begin
         if (i == bir_pkg::B_PERIOD) continue;
         axw(bir_pkg::OFS_ENABLE, 32'h1 << i);
         loc_req[i] <= 1'b1;
         tick(6);
         chk("local mirq", 32'(mirq), 32'h1);
         chk("local vector", 32'(irq_vector), (i < 3) ? 32'hC0 + i
            : 32'(bir_pkg::LOCAL_BASE) + i);
         loc_req[i] <= 1'b0;
         tick(5);
         chk("sticky mirq", 32'(mirq), 32'h1);
         axw(bir_pkg::OFS_CLEAR, 32'h1 << i);
         tick(3);
         chk("cleared mirq", 32'(mirq), 32'h0);
      end
      loc_req[6] <= 1'b1;
      tick(6);
      chk("disabled timer", 32'(mirq), 32'h0);
      axr(bir_pkg::OFS_STATUS);
      chk("timer status", rd, 32'h40);
      axw(bir_pkg::OFS_ENABLE, 32'h40);
      tick(3);
      chk("enabled timer", 32'(mirq), 32'h1);
      loc_req[6] <= 1'b0;
      axw(bir_pkg::OFS_CLEAR, 32'h7FF);
      axw(bir_pkg::OFS_ENABLE, 32'h0);
      $display("test local sources done");
      for (int i = 0; i < 4; i++) begin
         axw(bir_pkg::OFS_RATE, 32'(rates[i]));
         axw(bir_pkg::OFS_CLEAR, 32'h10);
         tick(waits[i]);
         axr(bir_pkg::OFS_STATUS);
         chk("periodic", 32'(rd[4]), 32'(i < 3));
      end
      $display("test periodic done");
      axw(bir_pkg::OFS_AUTOV, 32'h2A);
      for (int l = 1; l < 7; l++) begin
         vme_req[l] <= 1'b1;
         axw(bir_pkg::OFS_VMASK, 32'h0);
         tick(5);
         chk("vme mirq", 32'(mirq), 32'h1);
         chk("vme nmi", 32'(nmi), 32'h0);
         chk("from bus", 32'(vec_from_bus), 32'(l % 2 == 0));
         chk("vme vector", 32'(irq_vector), (l % 2)
            ? 32'(bir_pkg::AUTOV_BASE) + l : 32'h0);
         axr(bir_pkg::OFS_VECTOR);
         chk("vector reg", rd, (l % 2) ? 32'(bir_pkg::AUTOV_BASE) + l
            : 32'h100);
         axr(bir_pkg::OFS_VPEND);
         chk("pending level", rd, 32'h1 << l);
         axw(bir_pkg::OFS_VMASK, 32'h1 << l);
         tick(5);
         chk("masked level", 32'(mirq), 32'h0);
         vme_req[l] <= 1'b0;
      end
      $display("test vme levels done");
      for (int k = 0; k < 3; k++) begin
         abort_req <= (k == 0);
         vme_req[7] <= (k == 1);
         tick(5);
         chk("nmi", 32'(nmi), 32'(k < 2));
         chk("nmi apart", 32'(mirq), 32'h0);
      end
      $display("test nmi done");
      conclude();
   end
endmodule
